// [logic/sst_trailer_defines.vh]
// Constants for the subsector trailer and transfer error block.
// Assumes a 250 MHz core clock; times are turned into cycle counts here.
`ifndef SST_TRAILER_DEFINES_VH
`define SST_TRAILER_DEFINES_VH

// ****************************************
// Clock and timing
// ****************************************
`define SST_CLK_MHZ        250
`define SST_STROBE_NS      200
`define SST_STROBE_CYC     ((`SST_STROBE_NS * `SST_CLK_MHZ) / 1000)
`define SST_HANG_NS        300
`define SST_HANG_CYC       ((`SST_HANG_NS * `SST_CLK_MHZ) / 1000)
`define SST_TMR_W          8

// ****************************************
// Subsector framing
// ****************************************
`define SST_LAST_BIT       4'hF
`define SST_PRE_LAST_WORD  4'hE
`define SST_READ_PRELOAD   4'hF

// ****************************************
// Error status field positions
// ****************************************
`define SST_ERR_FAIL       10
`define SST_ERR_PROT       11
`define SST_ERR_LATE       12
`define SST_ERR_BADLOC     13
`define SST_ERR_RDCHK      14
`define SST_ERR_SUM        15
`define SST_ERR_LSB        10
`define SST_ERR_RESET      6'h00

// ****************************************
// Synchronised pin positions
// ****************************************
`define SST_PIN_WCLK       0
`define SST_PIN_RCLK       1
`define SST_PIN_RDY_N      2
`define SST_PIN_SYNC_N     3
`define SST_PIN_MATCH      4
`define SST_PIN_PROT_N     5
`define SST_PIN_NUM        6
`define SST_PIN_RESET      6'h0F

`endif

// [logic/sst_sync_edge.v]
// Two-stage synchroniser bank with edge detection on the settled stage.
// Assumes every input is asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none

module sst_sync_edge #(
  parameter       W         = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input  wire         clk,
  input  wire         rstn,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] level,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);

  // ****************************************
  // Per-bit synchroniser
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      reg last_q;
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          meta_q <= RST_VAL[i];
          sync_q <= RST_VAL[i];
          last_q <= RST_VAL[i];
        end else begin
          meta_q <= async_in[i];
          sync_q <= meta_q;
          last_q <= sync_q;
        end
      end
      assign level[i] = sync_q;
      assign rise[i]  = sync_q & ~last_q;
      assign fall[i]  = ~sync_q & last_q;
    end
  endgenerate

endmodule
`default_nettype wire

// [logic/sst_trailer.v]
// Subsector trailer sequencer and transfer error logic.
// Assumes disc pins are asynchronous; processor-side flags are on core_clk.
//
// Operation
// [R01] Check phase after fifteen data words; the code enters it after sixteen.
// [R02] Check phase sends code word, blocks data.
// [R03] Sixteenth check clock: parity on, check off.
// [R04] Parity phase writes one odd parity bit.
// [R05] Parity end fires strobe, drops write latch.
// [R06] Write strobe pulses done and write go.
// [R07] Repeat per subsector; end on end+empty.
// [R08] Read preload fifteen: 241 clocks to last word.
// [R09] Read strobe drops read latch, pulses go.
// [R10] Read ends on read finish signal.
// [R11] Status bits 10 to 14 per error.
// [R12] Bit 15 summarises the other errors.
// [R13] Ready loss during transfer sets drive failure.
// [R14] Retriggered hang timer expiry sets drive failure.
// [R15] Drive failure ends, drops busy, interrupts.
// [R16] Protected write sector sets protect error.
// [R17] Protect error ends when sector match drops.
// [R18] Late write data sets error next clock.
// [R19] Late read answer sets error at once.
// [R20] Status strobe drives six error bits.
// [R21] Strobe and hang timer are cycle counts.
`include "sst_trailer_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module sst_trailer (
  input  wire        core_clk,
  input  wire        rstn,
  input  wire        write_bit_clock,
  input  wire        read_bit_clock,
  input  wire        drive_ready_n,
  input  wire        subsector_sync_n,
  input  wire        sector_match,
  input  wire        protected_location_n,
  input  wire        op_init,
  input  wire        write_op_flag,
  input  wire        read_op_flag,
  input  wire        write_sector_mode,
  input  wire        write_data_bit,
  input  wire        check_word_bit,
  input  wire        end_cond,
  input  wire        buffer_empty_flag,
  input  wire        buffer_full_flag,
  input  wire        late_write_data_n,
  input  wire        late_read_data_n,
  input  wire        read_finish_n,
  input  wire        bad_location_error,
  input  wire        read_check_error,
  input  wire        interrupt_disable_flag,
  input  wire        status_read_strobe,
  output reg         check_word_phase,
  output reg         parity_phase,
  output reg         data_inhibit,
  output reg         disc_write_data,
  output reg         last_word_flag,
  output reg         write_sector_latch,
  output reg         read_sector_latch,
  output reg         subsector_end_strobe,
  output reg         subsector_done_pulse,
  output reg         write_sector_go,
  output reg         read_sector_go,
  output reg         error_end_n,
  output reg         selected_busy_n,
  output reg         interrupt_request,
  output reg  [5:0]  status_data,
  output reg         status_oe
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire [`SST_PIN_NUM-1:0] pin_lvl;
  wire [`SST_PIN_NUM-1:0] pin_rise;
  wire [`SST_PIN_NUM-1:0] pin_fall;

  sst_sync_edge #(
    .W       (`SST_PIN_NUM),
    .RST_VAL (`SST_PIN_RESET)
  ) u_sync (
    .clk      (core_clk),
    .rstn     (rstn),
    .async_in ({protected_location_n, sector_match, subsector_sync_n,
                drive_ready_n, read_bit_clock, write_bit_clock}),
    .level    (pin_lvl),
    .rise     (pin_rise),
    .fall     (pin_fall)
  );

  // ****************************************
  // State registers
  // ****************************************
  reg [3:0]             bit_cnt_q;
  reg [3:0]             word_cnt_q;
  reg                   skip_q;
  reg                   par_acc_q;
  reg [`SST_TMR_W-1:0]  strobe_cnt_q;
  reg [`SST_TMR_W-1:0]  hang_cnt_q;
  reg                   wgo_state_q;
  reg                   rgo_state_q;
  reg                   busy_q;
  reg                   late_wr_pend_q;
  reg                   late_wr_last_q;
  reg                   prot_pend_q;
  reg [5:0]             err_q;

  localparam integer          STROBE_INT  = `SST_STROBE_CYC;
  localparam integer          HANG_INT    = `SST_HANG_CYC;
  localparam [`SST_TMR_W-1:0] STROBE_LOAD = STROBE_INT[`SST_TMR_W-1:0];
  localparam [`SST_TMR_W-1:0] HANG_LOAD   = HANG_INT[`SST_TMR_W-1:0];

  // ****************************************
  // Bit clock selection
  // ****************************************
  wire wclk_ev  = pin_rise[`SST_PIN_WCLK] & write_sector_latch;
  wire rclk_ev  = pin_rise[`SST_PIN_RCLK] & read_sector_latch;
  wire bclk_ev  = wclk_ev | rclk_ev;
  wire bit_last = (bit_cnt_q == `SST_LAST_BIT);
  wire in_data  = ~check_word_phase & ~parity_phase;

  wire enter_check  = bclk_ev & ~skip_q & in_data & bit_last &
                      (word_cnt_q == `SST_LAST_BIT);
  wire enter_parity = bclk_ev & check_word_phase & bit_last;
  wire leave_parity = bclk_ev & parity_phase;

  wire strobe_on  = (strobe_cnt_q != {`SST_TMR_W{1'b0}});
  wire fail_event;
  wire prot_event;
  wire err_end;
  wire wr_finish  = wgo_state_q & end_cond & buffer_empty_flag;
  wire rd_finish  = rgo_state_q & ~read_finish_n;

  // ****************************************
  // Bit and word counting, trailer phases
  // ****************************************
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_q        <= 4'h0;
      word_cnt_q       <= 4'h0;
      skip_q           <= 1'b0;
      par_acc_q        <= 1'b0;
      check_word_phase <= 1'b0;
      parity_phase     <= 1'b0;
    end else if (op_init || strobe_on) begin
      bit_cnt_q        <= 4'h0;
      word_cnt_q       <= 4'h0;
      skip_q           <= 1'b0;
      par_acc_q        <= 1'b0;
      check_word_phase <= 1'b0;
      parity_phase     <= 1'b0;
      if (rgo_state_q || (op_init && read_op_flag)) begin
        bit_cnt_q <= `SST_READ_PRELOAD; // R08
        skip_q    <= 1'b1; // R08
      end
    end else if (bclk_ev) begin
      if (skip_q) begin
        bit_cnt_q <= 4'h0; // R08
        skip_q    <= 1'b0;
      end else begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        if (bit_last && in_data) begin
          word_cnt_q <= word_cnt_q + 4'h1;
        end
        if (in_data || check_word_phase) begin
          par_acc_q <= par_acc_q ^ disc_write_data;
        end
      end
      if (enter_check) begin
        check_word_phase <= 1'b1; // R01
      end
      if (enter_parity) begin
        check_word_phase <= 1'b0; // R03
        parity_phase     <= 1'b1; // R03
      end
      if (leave_parity) begin
        parity_phase <= 1'b0; // R05
      end
    end
  end

  // ****************************************
  // Write path selection
  // ****************************************
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      disc_write_data <= 1'b0;
      data_inhibit    <= 1'b0;
      last_word_flag  <= 1'b0;
    end else begin
      data_inhibit   <= check_word_phase | parity_phase; // R02 R04
      last_word_flag <= (word_cnt_q == `SST_LAST_BIT) & ~skip_q;
      if (check_word_phase) begin
        disc_write_data <= check_word_bit; // R02
      end else if (parity_phase) begin
        disc_write_data <= ~par_acc_q; // R04
      end else begin
        disc_write_data <= write_data_bit;
      end
    end
  end

  // ****************************************
  // End strobe and sector go requests
  // ****************************************
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      strobe_cnt_q         <= {`SST_TMR_W{1'b0}};
      subsector_end_strobe <= 1'b0;
      subsector_done_pulse <= 1'b0;
      write_sector_go      <= 1'b0;
      read_sector_go       <= 1'b0;
    end else begin
      if (leave_parity) begin
        strobe_cnt_q <= STROBE_LOAD; // R05 R21
      end else if (strobe_on) begin
        strobe_cnt_q <= strobe_cnt_q - {{(`SST_TMR_W-1){1'b0}}, 1'b1};
      end
      subsector_end_strobe <= strobe_on;
      subsector_done_pulse <= strobe_on & wgo_state_q; // R06
      write_sector_go      <= (strobe_on | op_init & write_op_flag) &
                              (wgo_state_q | op_init); // R06
      read_sector_go       <= (strobe_on | op_init & read_op_flag) &
                              (rgo_state_q | op_init); // R09
    end
  end

  // ****************************************
  // Sector latches and operation state
  // ****************************************
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      write_sector_latch <= 1'b0;
      read_sector_latch  <= 1'b0;
      wgo_state_q        <= 1'b0;
      rgo_state_q        <= 1'b0;
    end else begin
      if (op_init) begin
        wgo_state_q <= write_op_flag;
        rgo_state_q <= read_op_flag & ~write_op_flag;
      end else begin
        if (wr_finish || err_end) begin
          wgo_state_q <= 1'b0; // R07
        end
        if (rd_finish || err_end) begin
          rgo_state_q <= 1'b0; // R10
        end
      end
      if (leave_parity || err_end) begin
        write_sector_latch <= 1'b0; // R05
        read_sector_latch  <= 1'b0; // R09
      end else if (pin_rise[`SST_PIN_MATCH] && !strobe_on) begin
        write_sector_latch <= wgo_state_q & ~prot_event; // R07
        read_sector_latch  <= rgo_state_q; // R07
      end
    end
  end

  // ****************************************
  // Hang timer
  // ****************************************
  wire retrigger = op_init | write_sector_go | read_sector_go;
  wire hang_out  = busy_q & ~err_q[`SST_ERR_FAIL - `SST_ERR_LSB] &
                   (hang_cnt_q == {{(`SST_TMR_W-1){1'b0}}, 1'b1});

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hang_cnt_q <= {`SST_TMR_W{1'b0}};
    end else if (retrigger) begin
      hang_cnt_q <= HANG_LOAD; // R14 R21
    end else if (hang_cnt_q != {`SST_TMR_W{1'b0}}) begin
      hang_cnt_q <= hang_cnt_q - {{(`SST_TMR_W-1){1'b0}}, 1'b1}; // R14
    end
  end

  // ****************************************
  // Error detection
  // ****************************************
  wire ready_lost = pin_rise[`SST_PIN_RDY_N] &
                    (write_sector_latch | read_sector_latch);

  assign fail_event = ready_lost | hang_out; // R13 R14
  assign prot_event = pin_rise[`SST_PIN_SYNC_N] & pin_lvl[`SST_PIN_MATCH] &
                      write_sector_mode & wgo_state_q &
                      ~pin_lvl[`SST_PIN_PROT_N]; // R16
  wire   late_wr    = late_wr_pend_q & wclk_ev; // R18
  wire   late_rd    = ~late_read_data_n & rgo_state_q; // R19

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      err_q          <= `SST_ERR_RESET;
      late_wr_pend_q <= 1'b0;
      late_wr_last_q <= 1'b1;
      prot_pend_q    <= 1'b0;
    end else begin
      late_wr_last_q <= late_write_data_n;
      if (late_wr) begin
        late_wr_pend_q <= 1'b0;
      end
      if (late_wr_last_q && !late_write_data_n && buffer_empty_flag) begin
        late_wr_pend_q <= 1'b1; // R18
      end
      if (prot_pend_q && pin_fall[`SST_PIN_MATCH]) begin
        prot_pend_q <= 1'b0; // R17
      end
      if (op_init) begin
        err_q       <= `SST_ERR_RESET;
        prot_pend_q <= 1'b0;
      end
      if (fail_event) begin
        err_q[`SST_ERR_FAIL - `SST_ERR_LSB] <= 1'b1; // R11 R13
      end
      if (prot_event) begin
        err_q[`SST_ERR_PROT - `SST_ERR_LSB] <= 1'b1; // R11 R16
        prot_pend_q                         <= 1'b1; // R17
      end
      if (late_wr || (late_rd && buffer_full_flag)) begin
        err_q[`SST_ERR_LATE - `SST_ERR_LSB] <= 1'b1; // R18 R19
      end
      if (bad_location_error) begin
        err_q[`SST_ERR_BADLOC - `SST_ERR_LSB] <= 1'b1; // R11
      end
      if (read_check_error) begin
        err_q[`SST_ERR_RDCHK - `SST_ERR_LSB] <= 1'b1; // R11
      end
      if (fail_event || prot_event || late_wr || late_rd && buffer_full_flag ||
          bad_location_error || read_check_error) begin
        err_q[`SST_ERR_SUM - `SST_ERR_LSB] <= 1'b1; // R12
      end
    end
  end

  // ****************************************
  // Termination, busy and interrupt
  // ****************************************
  assign err_end = fail_event | (prot_pend_q & pin_fall[`SST_PIN_MATCH]);

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busy_q            <= 1'b0;
      error_end_n       <= 1'b1;
      selected_busy_n   <= 1'b1;
      interrupt_request <= 1'b0;
    end else begin
      error_end_n       <= ~(fail_event | prot_pend_q); // R15 R17
      interrupt_request <= 1'b0;
      if (op_init) begin
        busy_q <= 1'b1;
      end else if (busy_q && (err_end || wr_finish || rd_finish)) begin
        busy_q            <= 1'b0; // R15 R17
        interrupt_request <= ~interrupt_disable_flag; // R15 R17
      end
      selected_busy_n <= ~busy_q; // R15
    end
  end

  // ****************************************
  // Status read port
  // ****************************************
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      status_data <= `SST_ERR_RESET;
      status_oe   <= 1'b0;
    end else begin
      status_oe <= status_read_strobe; // R20
      if (status_read_strobe) begin
        status_data <= err_q; // R20
      end else begin
        status_data <= `SST_ERR_RESET;
      end
    end
  end

endmodule
`default_nettype wire

// [sim/sst_trailer_sva.sv]
// Port-level checks for the subsector trailer and transfer error block.
// Assumes it is bound to sst_trailer and that all checks run on core_clk.
`timescale 1ns/100ps
`default_nettype none
module sst_trailer_sva (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       op_init,
  input wire logic       write_op_flag,
  input wire logic       interrupt_disable_flag,
  input wire logic       status_read_strobe,
  input wire logic       check_word_phase,
  input wire logic       parity_phase,
  input wire logic       data_inhibit,
  input wire logic       write_sector_latch,
  input wire logic       read_sector_latch,
  input wire logic       subsector_end_strobe,
  input wire logic       write_sector_go,
  input wire logic       read_sector_go,
  input wire logic       selected_busy_n,
  input wire logic       interrupt_request,
  input wire logic [5:0] status_data,
  input wire logic       status_oe
);
  // ****************************************
  // Cycle counters
  // ****************************************
  logic [6:0] st_q;
  logic [7:0] idle_q;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q   <= 7'h00;
      idle_q <= 8'h00;
    end else begin
      st_q   <= subsector_end_strobe ? st_q + 7'h01 : 7'h00;
      idle_q <= (selected_busy_n | write_sector_go | read_sector_go) ? 8'h00 : idle_q + 8'h01;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_parity_end;
    parity_phase ##1 !parity_phase;
  endsequence
  // ****************************************
  // Properties
  // ****************************************
  a_inhibit_phase: assert property ((check_word_phase | parity_phase) |=> data_inhibit)
    else $error("data not inhibited in trailer phase");
  a_parity_swap: assert property ($rose(parity_phase) |-> $fell(check_word_phase))
    else $error("parity phase without check phase exit");
  a_strobe_cause: assert property (s_parity_end |=> subsector_end_strobe
    && !write_sector_latch && !read_sector_latch) else $error("parity end without strobe");
  a_strobe_length: assert property ($fell(subsector_end_strobe) |-> st_q == 7'h32)
    else $error("end strobe length wrong");
  a_strobe_go: assert property ($rose(subsector_end_strobe) && !selected_busy_n
    |-> write_sector_go | read_sector_go) else $error("end strobe without go request");
  a_init_go: assert property (op_init && write_op_flag |-> ##[1:3] write_sector_go
    ##[0:2] !selected_busy_n) else $error("no go request after start");
  a_hang_bound: assert property (idle_q < 8'h5A)
    else $error("busy without go request too long");
  a_status_idle: assert property (!status_oe |-> status_data == 6'h00)
    else $error("status data without strobe");
  a_status_answer: assert property (status_read_strobe ##1 status_read_strobe |-> status_oe)
    else $error("status strobe not answered");
  a_summary_bit: assert property (status_oe && (|status_data[4:0]) |-> status_data[5])
    else $error("summary bit missing");
  a_irq_masked: assert property (interrupt_request |-> !interrupt_disable_flag)
    else $error("interrupt while disabled");
  a_end_irq: assert property ($rose(selected_busy_n) && !interrupt_disable_flag
    |-> interrupt_request | $past(interrupt_request)) else $error("end without interrupt");
endmodule
`default_nettype wire

// [sim/sst_disc_model.sv]
// Behavioural disc unit driving bit clock, readiness, sync and sector pins.
// Assumes the bench calls its tasks; pins move asynchronously to core_clk.
`timescale 1ns/100ps
`default_nettype none
module sst_disc_model (
  output logic write_bit_clock,
  output logic read_bit_clock,
  output logic drive_ready_n,
  output logic subsector_sync_n,
  output logic sector_match,
  output logic protected_location_n
);
  // Bit clocks stand high between frames.
  initial begin
    write_bit_clock = 1'h1;
    read_bit_clock = 1'h1;
    drive_ready_n = 1'h0;
    subsector_sync_n = 1'h1;
    sector_match = 1'h0;
    protected_location_n = 1'h1;
  end
  task automatic pins(input logic m, input logic r, input logic p);
    sector_match = m;
    drive_ready_n = r;
    protected_location_n = p;
  endtask
  task automatic sync_pulse;
    subsector_sync_n = 1'h0;
    #16;
    subsector_sync_n = 1'h1;
    #16;
  endtask
  task automatic wclk(input int n);
    repeat (n) begin
      write_bit_clock = 1'h0;
      #16;
      write_bit_clock = 1'h1;
      #16;
    end
  endtask
endmodule
`default_nettype wire

// [sim/tb_sst_trailer.sv]
// Self-checking bench for the subsector trailer and transfer error block.
// Assumes the disc model drives the disc pins; the bench plays the processor.
`timescale 1ns/100ps
`default_nettype none
module tb_sst_trailer;
  logic core_clk = 1'h0, rstn = 1'h0, op_init = 1'h0;
  logic write_op_flag = 1'h0, read_op_flag = 1'h0, write_sector_mode = 1'h0;
  logic write_data_bit = 1'h0, check_word_bit = 1'h0, end_cond = 1'h0;
  logic buffer_empty_flag = 1'h0, buffer_full_flag = 1'h0, late_write_data_n = 1'h1;
  logic late_read_data_n = 1'h1, read_finish_n = 1'h1, bad_location_error = 1'h0;
  logic read_check_error = 1'h0, interrupt_disable_flag = 1'h0, status_read_strobe = 1'h0;
  wire  write_bit_clock, read_bit_clock, drive_ready_n, subsector_sync_n;
  wire  sector_match, protected_location_n, check_word_phase, parity_phase;
  wire  data_inhibit, disc_write_data, last_word_flag, write_sector_latch;
  wire  read_sector_latch, subsector_end_strobe, subsector_done_pulse, write_sector_go;
  wire  read_sector_go, error_end_n, selected_busy_n, interrupt_request, status_oe;
  wire  [5:0] status_data;
  int   miscompares = 0, n_compared = 0, cyc = 0, n_irq = 0, i0 = 0;
  always #2 core_clk = ~core_clk;
  sst_disc_model u_disc (.write_bit_clock, .read_bit_clock, .drive_ready_n,
    .subsector_sync_n, .sector_match, .protected_location_n);
  sst_trailer u_sst_trailer (.*);
  // ****************************************
  // Tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk6(input logic [5:0] got, input logic [5:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk6({5'h00, got}, {5'h00, exp});
  endtask
  task automatic rd(input logic [5:0] exp);
    status_read_strobe = 1'h1;
    tick(2);
    chk1(status_oe, 1'h1);
    chk6(status_data, exp);
    status_read_strobe = 1'h0;
    tick(1);
  endtask
  task automatic start(input logic w, input logic r);
    logic seen;
    seen = 1'h0;
    write_op_flag = w;
    read_op_flag = r;
    op_init = 1'h1;
    tick(1);
    op_init = 1'h0;
    repeat (4) begin
      seen = seen | write_sector_go | read_sector_go;
      tick(1);
    end
    chk1(seen, 1'h1);
    chk1(selected_busy_n, 1'h0);
  endtask
  task automatic wait_busy(input int n);
    for (int i = 0; i < n && selected_busy_n !== 1'h1; i++) tick(1);
    chk1(selected_busy_n, 1'h1);
  endtask
  task automatic conclude;
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (interrupt_request === 1'h1) n_irq++;
    if (cyc == 6000) begin
      miscompares++;
      conclude();
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    tick(12);
    rstn = 1'h1;
    tick(3);
    chk1(error_end_n, 1'h1);
    rd(6'h00);
    bad_location_error = 1'h1;
    tick(1);
    bad_location_error = 1'h0;
    rd(6'h28);
    read_check_error = 1'h1;
    tick(1);
    read_check_error = 1'h0;
    rd(6'h38);
    i0 = n_irq;
    start(1'h1, 1'h0);
    tick(55);
    rd(6'h00);
    wait_busy(40);
    rd(6'h21);
    chk6(6'(n_irq - i0), 6'h01);
    interrupt_disable_flag = 1'h1;
    i0 = n_irq;
    start(1'h1, 1'h0);
    u_disc.pins(1'h1, 1'h0, 1'h1);
    tick(6);
    chk1(write_sector_latch, 1'h1);
    u_disc.pins(1'h1, 1'h1, 1'h1);
    wait_busy(20);
    rd(6'h21);
    chk6(6'(n_irq - i0), 6'h00);
    u_disc.pins(1'h0, 1'h0, 1'h1);
    interrupt_disable_flag = 1'h0;
    write_sector_mode = 1'h1;
    start(1'h1, 1'h0);
    u_disc.pins(1'h1, 1'h0, 1'h0);
    u_disc.sync_pulse();
    tick(6);
    chk1(error_end_n, 1'h0);
    rd(6'h22);
    u_disc.pins(1'h0, 1'h0, 1'h1);
    wait_busy(20);
    write_sector_mode = 1'h0;
    start(1'h0, 1'h1);
    buffer_full_flag = 1'h1;
    late_read_data_n = 1'h0;
    tick(2);
    rd(6'h24);
    buffer_full_flag = 1'h0;
    late_read_data_n = 1'h1;
    wait_busy(90);
    buffer_empty_flag = 1'h1;
    start(1'h1, 1'h0);
    u_disc.pins(1'h1, 1'h0, 1'h1);
    late_write_data_n = 1'h0;
    tick(6);
    rd(6'h00);
    u_disc.wclk(1);
    tick(6);
    rd(6'h24);
    late_write_data_n = 1'h1;
    u_disc.pins(1'h0, 1'h0, 1'h1);
    wait_busy(90);
    start(1'h0, 1'h1);
    read_finish_n = 1'h0;
    wait_busy(20);
    read_finish_n = 1'h1;
    start(1'h1, 1'h0);
    u_disc.pins(1'h1, 1'h0, 1'h1);
    tick(6);
    end_cond = 1'h1;
    wait_busy(20);
    check_word_bit = 1'h1;
    u_disc.wclk(240);
    tick(6);
    chk1(last_word_flag, 1'h1);
    chk1(check_word_phase, 1'h0);
    u_disc.wclk(16);
    tick(6);
    chk1(check_word_phase, 1'h1);
    chk1(data_inhibit, 1'h1);
    chk1(disc_write_data, 1'h1);
    u_disc.wclk(15);
    tick(6);
    chk1(parity_phase, 1'h0);
    u_disc.wclk(1);
    tick(6);
    chk1(parity_phase, 1'h1);
    chk1(check_word_phase, 1'h0);
    chk1(disc_write_data, 1'h1);
    u_disc.wclk(1);
    tick(6);
    chk1(subsector_end_strobe, 1'h1);
    chk1(write_sector_latch, 1'h0);
    tick(50);
    chk1(subsector_end_strobe, 1'h0);
    conclude();
  end
endmodule
bind sst_trailer sst_trailer_sva u_sva (.core_clk, .rstn, .op_init, .write_op_flag,
  .interrupt_disable_flag, .status_read_strobe, .check_word_phase, .parity_phase,
  .data_inhibit, .write_sector_latch, .read_sector_latch, .subsector_end_strobe,
  .write_sector_go, .read_sector_go, .selected_busy_n, .interrupt_request,
  .status_data, .status_oe);
`default_nettype wire
